// ==== crtc_timing_pkg.sv ====
// shared constants, carrier structs and the state record of the raster timing block
// assumes an indexed register port and one character-rate system clock
package crtc_timing_pkg;

   // ==========================================================
   // register indices on the indexed port
   localparam logic [7:0] IDX_VBLANK_END   = 8'h16;
   localparam logic [7:0] IDX_RASTER_MODE  = 8'h17;
   localparam logic [7:0] IDX_LINE_CMP_LOW = 8'h18;
   localparam logic [7:0] RD_UNMAPPED      = 8'h00;

   // ==========================================================
   // reset values, none are documented so all start at zero
   localparam logic [7:0]  VBLANK_END_RST   = 8'h00;
   localparam logic [7:0]  RASTER_MODE_RST  = 8'h00;
   localparam logic [7:0]  LINE_CMP_RST     = 8'h00;
   localparam logic [9:0]  VCOUNT_RST       = 10'h000;
   localparam logic [15:0] ADDR_RST         = 16'h0000;

   // ==========================================================
   // raster mode control field positions
   localparam int MODE_RETRACE_EN = 7;
   localparam int MODE_BYTE_SEL   = 6;
   localparam int MODE_ADDR_WRAP  = 5;
   localparam int MODE_COUNT_BY2  = 3;
   localparam int MODE_VCLK_DIV2  = 2;
   localparam int MODE_ROW_SEL14  = 1;
   localparam int MODE_CGA_OFF    = 0;

   // ==========================================================
   // extension register field positions
   localparam int LOCK_VBLANK_BIT = 0;
   localparam int LOCK_MODE_BIT   = 5;
   localparam int MEMSIZE_HI_BIT  = 7;
   localparam int MEMSIZE_LO_BIT  = 6;
   localparam int MISC_MAP_EN_BIT = 1;
   localparam int UL_DWORD_BIT    = 6;

   // ==========================================================
   // address pin positions with substitutions
   localparam int PIN_ROW_BIT0 = 13;
   localparam int PIN_ROW_BIT1 = 14;
   localparam int WRAP_LO_SRC  = 13;
   localparam int WRAP_HI_SRC  = 15;
   localparam int DWORD_SRC0   = 12;
   localparam int DWORD_SRC1   = 13;

   // ==========================================================
   // refresh address mapping modes
   typedef enum logic [1:0] {
      ADDR_BYTE,
      ADDR_WORD,
      ADDR_DWORD
   } addr_mode_t;

   // register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] index;
      logic [7:0] data;
   } regbus_req_t;

   // whole state of the timing block
   typedef struct packed {
      logic [7:0]  vblank_end_count;
      logic [7:0]  raster_mode_control;
      logic [7:0]  split_line_compare_low;
      logic [9:0]  vcount;
      logic        vdiv;
      logic        cdiv;
      logic [15:0] ma_cnt;
      logic [15:0] row_start;
      logic        vblank;
      logic        hretrace;
      logic        vretrace;
      logic [15:0] pins;
      logic [7:0]  rd_data;
      logic        rd_valid;
   } crtc_state_t;

   // double word wins over the byte/word select
   function automatic addr_mode_t decode_addr_mode(input logic ul_dword,
                                                   input logic byte_sel);
      if (ul_dword) begin
         decode_addr_mode = ADDR_DWORD;
      end else if (byte_sel) begin
         decode_addr_mode = ADDR_BYTE;
      end else begin
         decode_addr_mode = ADDR_WORD;
      end
   endfunction : decode_addr_mode

endpackage : crtc_timing_pkg

// ==== crtc_vblank_end_addr_mode_line_compare.sv ====
// raster timing slice: vertical blank end, refresh address mapping,
// counter rates and split-screen line compare, behind an indexed register port
// assumes all strobes are one-cycle pulses synchronous to sys_clk_in
//
// Functional notes
// [RULE1] vertical blank drops when the low eight counter bits equal the blank end register.
// [RULE2] software loads blank end with start minus one plus the blank width, low eight bits.
// [RULE3] the ten-bit blank start setting is one less than the line where blanking begins; the code begins blanking on the line equal to the setting.
// [RULE4] writes to the blank end register are dropped while lock bit 0 is one.
// [RULE5] writes to the mode control register are dropped while lock bit 5 is one.
// [RULE6] mode bit 7 low forces both retrace outputs inactive, high lets them run.
// [RULE7] word mode shifts counter bits down one pin and puts a high bit on pin 0.
// [RULE8] byte uses bit n, word bit n-1, double word bits 12 and 13 on pins 0 and 1, else n-2.
// [RULE9] the mapping applies only with memory size bits 7:6 zero or misc bit 1 set.
// [RULE10] underline bit 6 selects double word, otherwise mode bit 6 picks byte or word.
// [RULE11] word mode pin 0 takes counter bit 13 without wrap and bit 15 with wrap.
// [RULE12] the address counter steps every character clock, or every second with mode bit 3; the code steps it only on character ticks during active display.
// [RULE13] the vertical counter steps per horizontal retrace, or every second with mode bit 2.
// [RULE14] pin 14 shows row scan bit 1 unless mode bit 1 selects counter bit 14.
// [RULE15] pin 13 shows row scan bit 0 in active display unless mode bit 0 is set.
// [RULE16] a ten-bit line compare clears the row start address when the vertical count hits it.
// [RULE17] every register resets to zero and reads back what was last written.
`timescale 1ns/100ps
module crtc_vblank_end_addr_mode_line_compare (
   input  wire logic                         sys_clk_in,
   input  wire logic                         rst_in,
   input  wire crtc_timing_pkg::regbus_req_t reg_req_in,
   input  wire logic [7:0]                   ext_lock_register_in,
   input  wire logic [7:0]                   ext_memory_size_register_in,
   input  wire logic [7:0]                   ext_misc_control_register_in,
   input  wire logic [7:0]                   underline_location_reg_in,
   input  wire logic                         line_cmp_bit8_in,
   input  wire logic                         line_cmp_bit9_in,
   input  wire logic [9:0]                   vblank_start_in,
   input  wire logic [15:0]                  start_addr_in,
   input  wire logic [7:0]                   row_offset_in,
   input  wire logic                         frame_start_in,
   input  wire logic                         hsync_tick_in,
   input  wire logic                         char_tick_in,
   input  wire logic                         row_advance_in,
   input  wire logic                         display_active_in,
   input  wire logic [1:0]                   row_scan_in,
   input  wire logic                         hretrace_raw_in,
   input  wire logic                         vretrace_raw_in,
   output logic [15:0]                       refresh_addr_out,
   output logic                              vblank_out,
   output logic                              hretrace_out,
   output logic                              vretrace_out,
   output logic [9:0]                        vcount_out,
   output logic [7:0]                        rd_data_out,
   output logic                              rd_valid_out
);

   // ==========================================================
   // state record and decoded controls
   crtc_timing_pkg::crtc_state_t st_q;
   crtc_timing_pkg::crtc_state_t st_d;
   crtc_timing_pkg::addr_mode_t  addr_mode;
   logic [15:0]                  pins_nxt;
   logic [9:0]                   line_cmp;
   logic [9:0]                   vcount_nxt;
   logic                         table_en;
   logic                         v_step;
   logic                         c_step;
   logic                         lc_hit;
   logic                         end_hit;
   logic                         start_hit;
   logic                         wr_vbe;
   logic                         wr_mode;
   logic                         wr_lcl;
   logic [7:0]                   mode;

   assign mode = st_q.raster_mode_control;

   // address mode decode, double word overrides mode bit 6
   assign addr_mode = crtc_timing_pkg::decode_addr_mode(
                         underline_location_reg_in[crtc_timing_pkg::UL_DWORD_BIT],
                         mode[crtc_timing_pkg::MODE_BYTE_SEL]); // RULE10

   // the table only holds for the standard memory size settings or with misc bit 1 set
   assign table_en = ~(ext_memory_size_register_in[crtc_timing_pkg::MEMSIZE_HI_BIT] |
                       ext_memory_size_register_in[crtc_timing_pkg::MEMSIZE_LO_BIT]) |
                     ext_misc_control_register_in[crtc_timing_pkg::MISC_MAP_EN_BIT]; // RULE9

   // compare value is spread over three registers
   assign line_cmp = {line_cmp_bit9_in, line_cmp_bit8_in, st_q.split_line_compare_low}; // RULE16

   // write decode with the lock bits, line compare has no lock
   assign wr_vbe  = reg_req_in.wr && (reg_req_in.index == crtc_timing_pkg::IDX_VBLANK_END) &&
                    !ext_lock_register_in[crtc_timing_pkg::LOCK_VBLANK_BIT]; // RULE4
   assign wr_mode = reg_req_in.wr && (reg_req_in.index == crtc_timing_pkg::IDX_RASTER_MODE) &&
                    !ext_lock_register_in[crtc_timing_pkg::LOCK_MODE_BIT]; // RULE5
   assign wr_lcl  = reg_req_in.wr && (reg_req_in.index == crtc_timing_pkg::IDX_LINE_CMP_LOW);

   // rate dividers: the phase bit lets every second tick through
   assign v_step = hsync_tick_in && (!mode[crtc_timing_pkg::MODE_VCLK_DIV2] || st_q.vdiv); // RULE13
   assign c_step = char_tick_in && display_active_in &&
                   (!mode[crtc_timing_pkg::MODE_COUNT_BY2] || st_q.cdiv); // RULE12

   assign vcount_nxt = frame_start_in ? crtc_timing_pkg::VCOUNT_RST :
                       v_step ? st_q.vcount + 10'h001 : st_q.vcount;
   assign lc_hit    = v_step && !frame_start_in && (vcount_nxt == line_cmp);
   assign end_hit   = v_step && (vcount_nxt[7:0] == st_q.vblank_end_count);
   assign start_hit = v_step && (vcount_nxt == vblank_start_in);

   // ==========================================================
   // pin mapping, registered below so the pins come from flops
   refresh_addr_mapper u_mapper (
      .ma_in             (st_q.ma_cnt),
      .mode_in           (addr_mode),
      .table_en_in       (table_en),
      .wrap_in           (mode[crtc_timing_pkg::MODE_ADDR_WRAP]),
      .row_sel14_in      (mode[crtc_timing_pkg::MODE_ROW_SEL14]),
      .cga_off_in        (mode[crtc_timing_pkg::MODE_CGA_OFF]),
      .display_active_in (display_active_in),
      .row_scan_in       (row_scan_in),
      .pins_out          (pins_nxt)
   );

   // ==========================================================
   // next state
   always_comb begin
      st_d = st_q;
      // register writes
      if (wr_vbe) begin
         st_d.vblank_end_count = reg_req_in.data;
      end
      if (wr_mode) begin
         st_d.raster_mode_control = reg_req_in.data;
      end
      if (wr_lcl) begin
         st_d.split_line_compare_low = reg_req_in.data;
      end
      // read back of stored values, unmapped indices read zero
      st_d.rd_valid = reg_req_in.rd;
      if (reg_req_in.rd) begin
         case (reg_req_in.index)
            crtc_timing_pkg::IDX_VBLANK_END:   st_d.rd_data = st_q.vblank_end_count; // RULE17
            crtc_timing_pkg::IDX_RASTER_MODE:  st_d.rd_data = st_q.raster_mode_control;
            crtc_timing_pkg::IDX_LINE_CMP_LOW: st_d.rd_data = st_q.split_line_compare_low;
            default:                           st_d.rd_data = crtc_timing_pkg::RD_UNMAPPED;
         endcase
      end
      // vertical counter and its divide phase
      st_d.vcount = vcount_nxt; // RULE13
      if (frame_start_in) begin
         st_d.vdiv = 1'b0;
      end else if (hsync_tick_in) begin
         st_d.vdiv = !st_q.vdiv;
      end
      // character divide phase restarts every line
      if (hsync_tick_in || frame_start_in) begin
         st_d.cdiv = 1'b0;
      end else if (char_tick_in && display_active_in) begin
         st_d.cdiv = !st_q.cdiv;
      end
      // blank end wins when both compares hit the same line
      if (end_hit) begin
         st_d.vblank = 1'b0; // RULE1
      end else if (start_hit) begin
         st_d.vblank = 1'b1;
      end
      // row start and address counter, frame start first, then line compare over the line reload
      if (frame_start_in) begin
         st_d.row_start = start_addr_in;
         st_d.ma_cnt    = start_addr_in;
      end else if (lc_hit) begin
         st_d.row_start = crtc_timing_pkg::ADDR_RST; // RULE16
         st_d.ma_cnt    = crtc_timing_pkg::ADDR_RST;
      end else if (hsync_tick_in) begin
         if (row_advance_in) begin
            st_d.row_start = st_q.row_start + {7'h00, row_offset_in, 1'b0};
         end
         st_d.ma_cnt = st_d.row_start;
      end else if (c_step) begin
         st_d.ma_cnt = st_q.ma_cnt + 16'h0001; // RULE12
      end
      // retrace gating, no point letting a raw pulse out when disabled
      st_d.hretrace = mode[crtc_timing_pkg::MODE_RETRACE_EN] && hretrace_raw_in; // RULE6
      st_d.vretrace = mode[crtc_timing_pkg::MODE_RETRACE_EN] && vretrace_raw_in; // RULE6
      st_d.pins     = pins_nxt; // RULE8
   end

   // ==========================================================
   // state register, synchronous reset to all zero
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st_q <= '0; // RULE17
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state flops
   assign refresh_addr_out = st_q.pins;
   assign vblank_out       = st_q.vblank;
   assign hretrace_out     = st_q.hretrace;
   assign vretrace_out     = st_q.vretrace;
   assign vcount_out       = st_q.vcount;
   assign rd_data_out      = st_q.rd_data;
   assign rd_valid_out     = st_q.rd_valid;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   vblank_end_a: assert property (end_hit |=> !vblank_out) // RULE1
      else $error("vertical blank did not end on match");
   lock_vbe_a: assert property (reg_req_in.wr && reg_req_in.index == 8'h16 &&
                                ext_lock_register_in[0] |=> $stable(st_q.vblank_end_count)) // RULE4
      else $error("locked blank end register changed");
   lock_mode_a: assert property (reg_req_in.wr && reg_req_in.index == 8'h17 &&
                                 ext_lock_register_in[5] |=> $stable(mode)) // RULE5
      else $error("locked mode register changed");
   retrace_gate_a: assert property (!mode[7] |=> !hretrace_out && !vretrace_out) // RULE6
      else $error("retrace active while disabled");
   retrace_pass_a: assert property (mode[7] && hretrace_raw_in |=> hretrace_out) // RULE6
      else $error("retrace blocked while enabled");
   word_map_a: assert property (addr_mode == crtc_timing_pkg::ADDR_WORD && table_en &&
                                mode[1] && mode[0]
                                |=> refresh_addr_out[15:1] == $past(st_q.ma_cnt[14:0])) // RULE7
      else $error("word mode pins not shifted by one");
   wrap_pin_a: assert property (addr_mode == crtc_timing_pkg::ADDR_WORD && table_en
                                |=> refresh_addr_out[0] == ($past(mode[5]) ?
                                    $past(st_q.ma_cnt[15]) : $past(st_q.ma_cnt[13]))) // RULE11
      else $error("word mode pin 0 wrong source");
   dword_map_a: assert property (underline_location_reg_in[6] && table_en
                                 |=> refresh_addr_out[1:0] == $past(st_q.ma_cnt[13:12])) // RULE10
      else $error("double word low pins wrong");
   bypass_map_a: assert property (!table_en && mode[0]
                                  |=> refresh_addr_out[12:0] == $past(st_q.ma_cnt[12:0])) // RULE9
      else $error("mapping applied while disabled");
   row14_a: assert property (!mode[1] |=> refresh_addr_out[14] == $past(row_scan_in[1])) // RULE14
      else $error("pin 14 not row scan bit 1");
   cga13_a: assert property (!mode[0] && display_active_in
                             |=> refresh_addr_out[13] == $past(row_scan_in[0])) // RULE15
      else $error("pin 13 not row scan bit 0");
   vdiv_hold_a: assert property (mode[2] && hsync_tick_in && !st_q.vdiv && !frame_start_in
                                 |=> $stable(vcount_out)) // RULE13
      else $error("vertical counter stepped on odd retrace");
   cdiv_hold_a: assert property (mode[3] && char_tick_in && !st_q.cdiv && !hsync_tick_in &&
                                 !frame_start_in && !lc_hit |=> $stable(st_q.ma_cnt)) // RULE12
      else $error("address counter stepped on odd clock");
   line_cmp_a: assert property (lc_hit |=> st_q.row_start == 16'h0000 &&
                                vcount_out == $past(line_cmp)) // RULE16
      else $error("row start not cleared at line compare");
   // expected from the written data itself, so a lost write fires too
   readback_a: assert property (wr_lcl ##1 !reg_req_in.wr ##1 (reg_req_in.rd &&
                                reg_req_in.index == 8'h18 && !reg_req_in.wr)
                                |=> rd_data_out == $past(reg_req_in.data, 3)) // RULE17
      else $error("line compare read back wrong");

   cover_blank_end_c: cover property (vblank_out ##1 !vblank_out);
   cover_line_cmp_c:  cover property (lc_hit);
   cover_dword_c:     cover property (addr_mode == crtc_timing_pkg::ADDR_DWORD && c_step);
   cover_locked_c:    cover property (reg_req_in.wr && ext_lock_register_in[5]);

endmodule : crtc_vblank_end_addr_mode_line_compare

// ==== crtc_vblank_end_addr_mode_line_compare_test.sv ====
// self-checking bench for the raster timing slice
// assumes the package and design files are compiled first
`timescale 1ns/100ps
module crtc_vblank_end_addr_mode_line_compare_test;
   // ==========================================================
   // stimulus and observed signals
   logic                         sys_clk_in = 1'b0;
   logic                         rst_in     = 1'b1;
   crtc_timing_pkg::regbus_req_t req        = '0;
   logic [7:0]                   lock = 8'h00, msz = 8'h00, misc = 8'h00, ul = 8'h00, ro = 8'h00;
   logic                         lc8 = 1'b0, lc9 = 1'b0, fs = 1'b0, hs = 1'b0, ct = 1'b0;
   logic                         ra = 1'b0, act = 1'b0, hr = 1'b0, vr = 1'b0;
   logic [9:0]                   vbs = 10'h000;
   logic [15:0]                  sa  = 16'h0000;
   logic [1:0]                   rs  = 2'h0;
   logic [15:0]                  pins, fetched;
   logic                         vb, hro, vro, rdv;
   logic [9:0]                   vc;
   logic [7:0]                   rdd;
   int                           errors = 0, n_checks = 0, cycles = 0;

   always #10 sys_clk_in = ~sys_clk_in;

   crtc_vblank_end_addr_mode_line_compare dut_u (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_req_in(req),
      .ext_lock_register_in(lock), .ext_memory_size_register_in(msz),
      .ext_misc_control_register_in(misc), .underline_location_reg_in(ul),
      .line_cmp_bit8_in(lc8), .line_cmp_bit9_in(lc9), .vblank_start_in(vbs),
      .start_addr_in(sa), .row_offset_in(ro), .frame_start_in(fs), .hsync_tick_in(hs),
      .char_tick_in(ct), .row_advance_in(ra), .display_active_in(act), .row_scan_in(rs),
      .hretrace_raw_in(hr), .vretrace_raw_in(vr), .refresh_addr_out(pins),
      .vblank_out(vb), .hretrace_out(hro), .vretrace_out(vro), .vcount_out(vc),
      .rd_data_out(rdd), .rd_valid_out(rdv));

   display_mem_model mem_u (.sys_clk_in(sys_clk_in), .addr_in(pins), .data_out(fetched));

   // ==========================================================
   // shared tasks
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge sys_clk_in) req <= '{wr: 1'b1, rd: 1'b0, index: idx, data: d};
      @(posedge sys_clk_in) req <= '0;
   endtask : reg_wr

   // read answer lands on the same edge that takes the request
   task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
      @(posedge sys_clk_in) req <= '{wr: 1'b0, rd: 1'b1, index: idx, data: 8'h00};
      @(posedge sys_clk_in) req <= '0;
      #1 check({7'h00, rdv, rdd}, {8'h01, exp});
   endtask : reg_rd

   task automatic frame();
      @(posedge sys_clk_in) fs <= 1'b1;
      @(posedge sys_clk_in) fs <= 1'b0;
      @(posedge sys_clk_in) #1;
   endtask : frame

   task automatic hpulse();
      @(posedge sys_clk_in) hs <= 1'b1;
      @(posedge sys_clk_in) hs <= 1'b0;
      @(posedge sys_clk_in) #1;
   endtask : hpulse

   // expected pins worked out from the mapping table and substitutions
   function automatic logic [15:0] exp_map(input logic [15:0] ma, input logic [7:0] m);
      logic [15:0] p;
      p = ma;
      if (msz[7:6] == 2'b00 || misc[1]) begin
         if (ul[6]) p = {ma[13:0], ma[13], ma[12]};
         else if (!m[6]) p = {ma[14:0], m[5] ? ma[15] : ma[13]};
      end
      if (!m[1]) p[14] = rs[1];
      if (!m[0] && act) p[13] = rs[0];
      return p;
   endfunction : exp_map

   task automatic map_case(input logic [7:0] m, u, z, c, input logic a, input logic [1:0] r);
      reg_wr(8'h17, m);
      @(posedge sys_clk_in) begin
         ul   <= u;
         msz  <= z;
         misc <= c;
         act  <= a;
         rs   <= r;
         sa   <= 16'h9ac3;
      end
      frame();
      check(pins, exp_map(16'h9ac3, m));
   endtask : map_case

   // four character ticks during display, counter starts at zero
   task automatic count4(input logic [7:0] m, input logic [15:0] exp);
      reg_wr(8'h17, m);
      frame();
      @(posedge sys_clk_in) ct <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      ct <= 1'b0;
      @(posedge sys_clk_in) #1 check(pins, exp);
   endtask : count4

   // ==========================================================
   // hang guard, far above the fewer than two hundred cycles the run needs
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         complete_run();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      reg_rd(8'h16, 8'h00);
      reg_rd(8'h17, 8'h00);
      reg_rd(8'h18, 8'h00);
      reg_rd(8'h20, 8'h00);
      reg_wr(8'h16, 8'h5a);
      reg_rd(8'h16, 8'h5a);
      @(posedge sys_clk_in) lock <= 8'h01;
      reg_wr(8'h16, 8'ha5);
      reg_rd(8'h16, 8'h5a);
      reg_wr(8'h17, 8'h3c);
      reg_rd(8'h17, 8'h3c);
      @(posedge sys_clk_in) lock <= 8'h20;
      reg_wr(8'h17, 8'hc3);
      reg_rd(8'h17, 8'h3c);
      @(posedge sys_clk_in) lock <= 8'h00;
      map_case(8'hc3, 8'h00, 8'h00, 8'h00, 1'b0, 2'h0);
      map_case(8'h83, 8'h00, 8'h00, 8'h00, 1'b0, 2'h0);
      map_case(8'ha3, 8'h00, 8'h00, 8'h00, 1'b0, 2'h0);
      map_case(8'hc3, 8'h40, 8'h00, 8'h00, 1'b0, 2'h0);
      map_case(8'h83, 8'h00, 8'hc0, 8'h00, 1'b0, 2'h0);
      map_case(8'h83, 8'h00, 8'hc0, 8'h02, 1'b0, 2'h0);
      map_case(8'h81, 8'h00, 8'h00, 8'h00, 1'b0, 2'h2);
      map_case(8'h82, 8'h00, 8'h00, 8'h00, 1'b1, 2'h2);
      map_case(8'h82, 8'h00, 8'h00, 8'h00, 1'b0, 2'h2);
      @(posedge sys_clk_in) begin
         hr <= 1'b1;
         vr <= 1'b1;
      end
      reg_wr(8'h17, 8'h43);
      @(posedge sys_clk_in) #1 check({14'h0, hro, vro}, 16'h0000);
      reg_wr(8'h17, 8'hc3);
      @(posedge sys_clk_in) #1 check({14'h0, hro, vro}, 16'h0003);
      @(posedge sys_clk_in) begin
         sa  <= 16'h0000;
         act <= 1'b1;
      end
      count4(8'hc3, 16'h0004);
      count4(8'hcb, 16'h0002);
      @(posedge sys_clk_in) begin
         act <= 1'b0;
         sa  <= 16'h1234;
         vbs <= 10'h003;
      end
      // blank end is start setting plus a two line width
      reg_wr(8'h16, 8'h05);
      reg_wr(8'h18, 8'h02);
      reg_rd(8'h18, 8'h02);
      frame();
      hpulse();
      check({6'h0, vc}, 16'h0001);
      check(pins, 16'h1234);
      hpulse();
      check(pins, 16'h0000);
      hpulse();
      check({15'h0, vb}, 16'h0001);
      hpulse();
      check({15'h0, vb}, 16'h0001);
      hpulse();
      check({15'h0, vb}, 16'h0000);
      reg_wr(8'h17, 8'hc7);
      frame();
      hpulse();
      check({6'h0, vc}, 16'h0000);
      hpulse();
      check({6'h0, vc}, 16'h0001);
      complete_run();
   end
endmodule : crtc_vblank_end_addr_mode_line_compare_test

// ==== display_mem_model.sv ====
// display memory seen by the refresh address pins
// assumes one system clock; the fetched word feeds nothing in this slice
`timescale 1ns/100ps
module display_mem_model (
   input  wire logic        sys_clk_in,
   input  wire logic [15:0] addr_in,
   output logic [15:0]      data_out
);
   // ==========================================================
   // fetch path
   // scrambled word so that a stuck address never looks like good data
   always_ff @(posedge sys_clk_in) begin
      data_out <= ~addr_in ^ {addr_in[7:0], addr_in[15:8]};
   end
endmodule : display_mem_model

// ==== refresh_addr_mapper.sv ====
// combinational refresh address to pin mapping
// assumes the caller registers the result before it leaves the block
`timescale 1ns/100ps
module refresh_addr_mapper (
   input  wire logic [15:0]                ma_in,
   input  wire crtc_timing_pkg::addr_mode_t mode_in,
   input  wire logic                       table_en_in,
   input  wire logic                       wrap_in,
   input  wire logic                       row_sel14_in,
   input  wire logic                       cga_off_in,
   input  wire logic                       display_active_in,
   input  wire logic [1:0]                 row_scan_in,
   output logic [15:0]                     pins_out
);

   // ==========================================================
   // table lookup, falls back to straight byte mapping when disabled
   crtc_timing_pkg::addr_mode_t eff_mode;
   logic [15:0]                 mapped;

   assign eff_mode = table_en_in ? mode_in : crtc_timing_pkg::ADDR_BYTE; // RULE9

   // pin 0 carries a high counter bit in word mode
   assign mapped[0] = (eff_mode == crtc_timing_pkg::ADDR_WORD) ?
                      (wrap_in ? ma_in[crtc_timing_pkg::WRAP_HI_SRC]
                               : ma_in[crtc_timing_pkg::WRAP_LO_SRC]) : // RULE7 RULE11
                      (eff_mode == crtc_timing_pkg::ADDR_DWORD) ?
                      ma_in[crtc_timing_pkg::DWORD_SRC0] : ma_in[0]; // RULE8
   assign mapped[1] = (eff_mode == crtc_timing_pkg::ADDR_WORD) ? ma_in[0] :
                      (eff_mode == crtc_timing_pkg::ADDR_DWORD) ?
                      ma_in[crtc_timing_pkg::DWORD_SRC1] : ma_in[1]; // RULE8

   // upper pins shift down by one or two positions
   genvar gi;
   generate
      for (gi = 2; gi < 16; gi = gi + 1) begin : g_pin
         assign mapped[gi] = (eff_mode == crtc_timing_pkg::ADDR_WORD)  ? ma_in[gi-1] :
                             (eff_mode == crtc_timing_pkg::ADDR_DWORD) ? ma_in[gi-2] :
                             ma_in[gi]; // RULE7 RULE8
      end
   endgenerate

   // row scan substitutions for legacy text and graphics layouts
   always_comb begin
      pins_out = mapped;
      if (!row_sel14_in) begin
         pins_out[crtc_timing_pkg::PIN_ROW_BIT1] = row_scan_in[1]; // RULE14
      end
      if (!cga_off_in && display_active_in) begin
         pins_out[crtc_timing_pkg::PIN_ROW_BIT0] = row_scan_in[0]; // RULE15
      end
   end

endmodule : refresh_addr_mapper
